// ---- srs_map.svh ----
`ifndef SRS_MAP_SVH
`define SRS_MAP_SVH
// ------------------------------------------------------------
// Timing
// ------------------------------------------------------------
`define SRS_CLK_PERIOD_NS 100
`define SRS_HOLD_NS 1000
`define SRS_HOLD_CYC \
	((`SRS_HOLD_NS + `SRS_CLK_PERIOD_NS - 1) / `SRS_CLK_PERIOD_NS)
`define SRS_WDT_TIMEOUT_MS 3000
`define SRS_WDT_CYC \
	(`SRS_WDT_TIMEOUT_MS * (1000000 / `SRS_CLK_PERIOD_NS))
// ------------------------------------------------------------
// Encodings
// ------------------------------------------------------------
`define SRS_ACT_COLD 2'h0
`define SRS_ACT_WARM 2'h1
`define SRS_ACT_RU 2'h2
`define SRS_IMG_CUR 2'h0
`define SRS_IMG_NEXT 2'h1
`define SRS_IMG_FACTORY 2'h2
`define SRS_SRC_JTAG 3'h7
`endif

// ---- srs_pkg.sv ----
package srs_pkg;
	// Sequencer states
	typedef enum logic [2:0] {
		ST_IDLE     = 3'h0,
		ST_POR      = 3'h1,
		ST_COLD     = 3'h2,
		ST_LOAD     = 3'h3,
		ST_WARM     = 3'h4,
		ST_RU_ERASE = 3'h5,
		ST_RU_CFG   = 3'h6
	} srs_state_type;
	// Watchdog action and image select
	typedef logic [1:0] srs_act_type;
	typedef logic [1:0] srs_img_type;
endpackage

// ---- srs_sequencer.sv ----
`timescale 1ns/1ns
`include "srs_map.svh"
// Overview of operation
// - power-on reset clears subsystem and fabric
// - init start and tamper clear only after POR
// - config restart pin cold resets and reconfigures
// - cold keeps I/O, clock, reset, scratch, TAP
// - cold reset leaves fabric alone, no reconfig
// - cold reset reloads first stage loader
// - cold pin assertion starts cold sequence
// - watchdog remote update asserts then releases cold
// - erase fabric, load image, loader same image
// - warm keeps debug and scratch state
// - warm never reloads first stage loader
// - warm leaves fabric untouched, no reconfig
// - warm returns shared flash to config manager
// - per core software reset spares config manager
// - per core watchdogs, watchdog 0 boot, 3 s
// - watchdog action cold, warm or remote update
// - debug system reset starts a cold reset
// - JTAG reset whole device, JTAG config source
// - secure mode escalates warm and watchdog to POR
// - software cold drives pin low until done
module srs_sequencer #(
	parameter int NCORE   = 4,
	parameter int WDT_CYC = `SRS_WDT_CYC
) (
	input  wire logic                clk_sys,
	input  wire logic                rst,
	input  wire logic                config_restart_n,
	input  wire logic                cold_rst_pin_n,
	output wire logic                cold_rst_pin_out,
	output wire logic                cold_rst_pin_oe,
	input  wire logic                debug_system_reset_n,
	input  wire logic                jtag_reset_n,
	input  wire logic [2:0]          boot_select_pins,
	input  wire logic                secure_mode,
	input  wire logic                single_flash,
	input  wire logic                sw_cold_req,
	input  wire logic                warm_reset_request_reg,
	input  wire logic                wait_for_interrupt_state,
	input  wire logic [NCORE-1:0]    sw_core_rst,
	input  wire logic [NCORE-1:0]    wdt_start,
	input  wire logic [NCORE-1:0]    wdt_stop,
	input  wire logic [NCORE-1:0]    wdt_kick,
	input  wire srs_pkg::srs_act_type wdt_action,
	input  wire logic                next_image_valid,
	input  wire logic                fpga_cfg_done,
	input  wire logic                first_stage_loader_done,
	input  wire logic                flash_to_hps,
	output logic                     hps_main_rst_q,
	output logic                     hps_debug_rst_q,
	output logic                     hps_keep_rst_q,
	output logic                     fpga_rst_q,
	output logic                     fpga_erase_q,
	output logic                     fpga_cfg_req_q,
	output logic                     first_stage_loader_req_q,
	output srs_pkg::srs_img_type     img_q,
	output logic                     init_start_q,
	output logic                     tamper_clear_q,
	output logic                     flash_hps_q,
	output logic [2:0]               cfg_src_q,
	output logic [NCORE-1:0]         core_rst_q
);
	import srs_pkg::*;

	// ------------------------------------------------------------
	// Constants
	// ------------------------------------------------------------
	localparam int          WW      = $clog2(WDT_CYC + 1);
	localparam logic [WW-1:0] WDT_LIM = WW'(WDT_CYC - 1);
	localparam logic [7:0]  HOLD    = 8'(`SRS_HOLD_CYC - 1);
	localparam int          NS      = 7;

	// ------------------------------------------------------------
	// Pin synchronisers
	// ------------------------------------------------------------
	logic [NS-1:0] s1_q, s2_q, s3_q; // Stages, s3 feeds edge logic
	logic [NS-1:0] s1_d;             // Raw pin vector
	logic          cold_fall;        // Cold pin newly asserted
	logic          dbg_fall;         // Debug reset newly asserted
	logic          cfg_fall;         // Config restart newly asserted
	logic          jtag_req;         // JTAG reset level

	// Pins go through two flops before any logic looks at them
	always_comb begin
		s1_d = {boot_select_pins, jtag_reset_n, config_restart_n,
			debug_system_reset_n, cold_rst_pin_n};
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			s1_q <= {NS{1'b1}};
			s2_q <= {NS{1'b1}};
			s3_q <= {NS{1'b1}};
		end else begin
			s1_q <= s1_d;
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end

	// Own drive reads back low, so it must not retrigger a cold reset
	assign cold_fall = !s2_q[0] && s3_q[0] && !cold_rst_pin_oe;
	assign dbg_fall  = !s2_q[1] && s3_q[1];
	assign cfg_fall  = !s2_q[2] && s3_q[2];
	assign jtag_req  = !s2_q[3];

	// ------------------------------------------------------------
	// Watchdogs, one per core
	// ------------------------------------------------------------
	logic [WW-1:0]    wcnt_q [NCORE];
	logic [WW-1:0]    wcnt_d [NCORE];
	logic [NCORE-1:0] wen_q, wen_d;   // Watchdog running
	logic [NCORE-1:0] wfire;          // Timeout this cycle
	logic             boot_done;      // Sequence returns to idle
	logic             wdt_any;

	// Counters clear and hold at zero while the subsystem is held in reset
	always_comb begin
		wen_d = wen_q;
		for (int i = 0; i < NCORE; i++) begin
			wcnt_d[i] = wcnt_q[i];
			wfire[i]  = wen_q[i] && !hps_main_rst_q &&
				(wcnt_q[i] == WDT_LIM);
			if (hps_main_rst_q || wdt_kick[i] || wfire[i])
				wcnt_d[i] = '0;
			else if (wen_q[i])
				wcnt_d[i] = wcnt_q[i] + WW'(1);
			if (wdt_stop[i])
				wen_d[i] = 1'b0;
			if (wdt_start[i])
				wen_d[i] = 1'b1;
		end
		// Boot watchdog rearms on every release until the second
		// loader stops it
		if (boot_done)
			wen_d[0] = 1'b1;
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			wen_q <= '0;
			for (int i = 0; i < NCORE; i++)
				wcnt_q[i] <= '0;
		end else begin
			wen_q <= wen_d;
			for (int i = 0; i < NCORE; i++)
				wcnt_q[i] <= wcnt_d[i];
		end
	end

	assign wdt_any = |wfire;

	// ------------------------------------------------------------
	// Reset sequencer
	// ------------------------------------------------------------
	srs_state_type state_q, state_d; // Sequence state
	logic [7:0]    cnt_q, cnt_d;     // Hold counter
	logic          hold_done;
	logic          oe_q, oe_d;       // Driving the cold pin
	logic          warm_q, warm_d;   // Warm request pending
	logic          jtag_q, jtag_d;   // Last full reset from JTAG
	srs_img_type   img_d;
	logic          init_d, tamper_d, flash_d;
	logic [2:0]    src_d;

	assign hold_done = (cnt_q == HOLD);
	assign boot_done = (state_q != ST_IDLE) && (state_d == ST_IDLE);

	always_comb begin
		state_d  = state_q;
		cnt_d    = hold_done ? cnt_q : cnt_q + 8'h01;
		img_d    = img_q;
		oe_d     = oe_q;
		jtag_d   = jtag_q;
		init_d   = 1'b0;
		tamper_d = 1'b0;
		flash_d  = flash_hps_q;
		src_d    = cfg_src_q;
		// A new request wins over taking the old one
		warm_d   = warm_q || warm_reset_request_reg;
		if (jtag_req) begin
			// Whole device, from any state
			state_d = ST_POR;
			cnt_d   = 8'h00;
			jtag_d  = 1'b1;
			oe_d    = 1'b0;
		end else begin
			case (state_q)
			ST_IDLE: begin
				cnt_d = 8'h00;
				if (flash_to_hps)
					flash_d = 1'b1;
				if (secure_mode && (warm_q || wdt_any)) begin
					state_d = ST_POR;
					warm_d  = warm_reset_request_reg;
				end else if (cfg_fall) begin
					state_d = ST_RU_ERASE;
					img_d   = `SRS_IMG_CUR;
				end else if (wdt_any && wdt_action == `SRS_ACT_RU) begin
					// Factory image is the fallback
					state_d = ST_RU_ERASE;
					img_d   = next_image_valid ? `SRS_IMG_NEXT
						: `SRS_IMG_FACTORY;
				end else if (cold_fall || dbg_fall || sw_cold_req ||
					(wdt_any && wdt_action == `SRS_ACT_COLD)) begin
					state_d = ST_COLD;
					img_d   = `SRS_IMG_CUR;
					oe_d    = sw_cold_req;
				end else if ((warm_q && wait_for_interrupt_state) ||
					(wdt_any && wdt_action == `SRS_ACT_WARM)) begin
					// Software request waits for the other cores to park
					state_d = ST_WARM;
					warm_d  = warm_reset_request_reg;
					if (single_flash)
						flash_d = 1'b0;
				end
			end
			ST_POR: begin
				if (hold_done) begin
					state_d  = ST_IDLE;
					init_d   = 1'b1;
					tamper_d = 1'b1;
					src_d    = jtag_q ? `SRS_SRC_JTAG : s2_q[6:4];
					jtag_d   = 1'b0;
					flash_d  = 1'b0;
					warm_d   = warm_reset_request_reg;
				end
			end
			ST_COLD: begin
				if (hold_done) begin
					state_d = ST_LOAD;
					cnt_d   = 8'h00;
				end
			end
			ST_LOAD: begin
				cnt_d = 8'h00;
				if (first_stage_loader_done) begin
					state_d = ST_IDLE;
					oe_d    = 1'b0;
				end
			end
			ST_WARM: begin
				// Loader stays in RAM, no reload step
				if (hold_done)
					state_d = ST_IDLE;
			end
			ST_RU_ERASE: begin
				if (hold_done) begin
					state_d = ST_RU_CFG;
					cnt_d   = 8'h00;
				end
			end
			ST_RU_CFG: begin
				cnt_d = 8'h00;
				if (fpga_cfg_done)
					state_d = ST_LOAD;
			end
			default: state_d = ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			state_q        <= ST_POR;
			cnt_q          <= 8'h00;
			oe_q           <= 1'b0;
			warm_q         <= 1'b0;
			jtag_q         <= 1'b0;
			img_q          <= `SRS_IMG_CUR;
			init_start_q   <= 1'b0;
			tamper_clear_q <= 1'b0;
			flash_hps_q    <= 1'b0;
			cfg_src_q      <= 3'h0;
		end else begin
			state_q        <= state_d;
			cnt_q          <= cnt_d;
			oe_q           <= oe_d;
			warm_q         <= warm_d;
			jtag_q         <= jtag_d;
			img_q          <= img_d;
			init_start_q   <= init_d;
			tamper_clear_q <= tamper_d;
			flash_hps_q    <= flash_d;
			cfg_src_q      <= src_d;
		end
	end

	assign cold_rst_pin_oe  = oe_q;
	assign cold_rst_pin_out = 1'b0;

	// ------------------------------------------------------------
	// Reset outputs, registered from the next state
	// ------------------------------------------------------------
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			hps_main_rst_q  <= 1'b1;
			hps_debug_rst_q <= 1'b1;
			hps_keep_rst_q  <= 1'b1;
			fpga_rst_q      <= 1'b1;
			fpga_erase_q    <= 1'b0;
			fpga_cfg_req_q  <= 1'b0;
			first_stage_loader_req_q <= 1'b0;
			core_rst_q      <= '1;
		end else begin
			hps_main_rst_q  <= (state_d != ST_IDLE);
			hps_debug_rst_q <= (state_d != ST_IDLE) &&
				(state_d != ST_WARM);
			hps_keep_rst_q  <= (state_d == ST_POR);
			fpga_rst_q      <= (state_d == ST_POR);
			fpga_erase_q    <= (state_d == ST_RU_ERASE);
			fpga_cfg_req_q  <= (state_d == ST_RU_CFG);
			first_stage_loader_req_q <= (state_d == ST_LOAD);
			// Core resets never enter the sequencer state
			core_rst_q      <= sw_core_rst |
				{NCORE{state_d != ST_IDLE}};
		end
	end

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	// Erase spans the whole ten-cycle hold, then drops
	sequence s_ru_erase;
		fpga_erase_q [*8] ##1 fpga_erase_q [*2] ##1 !fpga_erase_q;
	endsequence
	sequence s_ru_cfg;
		fpga_cfg_req_q;
	endsequence
	property p_por_all;
		@(posedge clk_sys) disable iff (rst)
		state_q == ST_POR |-> hps_keep_rst_q && fpga_rst_q &&
			hps_main_rst_q;
	endproperty
	a_por_all: assert property (p_por_all)
		else $error("POR did not reset everything");
	property p_init;
		@(posedge clk_sys) disable iff (rst)
		init_start_q |-> $past(state_q) == ST_POR && tamper_clear_q;
	endproperty
	a_init: assert property (p_init)
		else $error("init started outside POR");
	property p_keep;
		@(posedge clk_sys) disable iff (rst)
		(hps_keep_rst_q || fpga_rst_q) |-> state_q == ST_POR;
	endproperty
	a_keep: assert property (p_keep)
		else $error("preserved domain reset outside POR");
	property p_warm;
		@(posedge clk_sys) disable iff (rst)
		state_q == ST_WARM |-> hps_main_rst_q && !hps_debug_rst_q &&
			!fpga_erase_q ##1 state_q != ST_LOAD;
	endproperty
	a_warm: assert property (p_warm)
		else $error("warm reset scope wrong");
	property p_ru;
		@(posedge clk_sys) disable iff (rst || jtag_req)
		$rose(fpga_erase_q) |-> s_ru_erase ##0 s_ru_cfg;
	endproperty
	a_ru: assert property (p_ru)
		else $error("erase not followed by load");
	property p_pin;
		@(posedge clk_sys) disable iff (rst || jtag_req)
		state_q == ST_IDLE && sw_cold_req && !secure_mode && !cfg_fall &&
			!wdt_any |=> cold_rst_pin_oe until state_q == ST_IDLE;
	endproperty
	a_pin: assert property (p_pin)
		else $error("cold pin released early");
	property p_secure;
		@(posedge clk_sys) disable iff (rst || jtag_req)
		state_q == ST_IDLE && secure_mode && wdt_any |=>
			state_q == ST_POR;
	endproperty
	a_secure: assert property (p_secure)
		else $error("watchdog not escalated in secure mode");
	property p_flash;
		@(posedge clk_sys) disable iff (rst)
		$rose(state_q == ST_WARM) && single_flash |-> !flash_hps_q;
	endproperty
	a_flash: assert property (p_flash)
		else $error("flash not returned on warm reset");
	property p_jtag;
		@(posedge clk_sys) disable iff (rst)
		jtag_req |=> state_q == ST_POR && jtag_q;
	endproperty
	a_jtag: assert property (p_jtag)
		else $error("JTAG reset not taken");
	property p_wdt;
		@(posedge clk_sys) disable iff (rst)
		wfire[0] |=> wcnt_q[0] == '0 && $past(wen_q[0]);
	endproperty
	a_wdt: assert property (p_wdt)
		else $error("watchdog fire without restart");
endmodule

// ---- srs_partner.sv ----
`timescale 1ns/1ns
// ------------------------------------------------------------
// Far side: config manager and processor cores
// ------------------------------------------------------------
module srs_partner #(
	parameter int NCORE = 4
) (
	input  wire logic             clk_sys,
	input  wire logic             rst,
	input  wire logic             hps_main_rst_q,
	input  wire logic             first_stage_loader_req_q,
	input  wire logic             fpga_cfg_req_q,
	input  wire logic [4:0]       dly,
	input  wire logic             hold_wdt,
	output logic                  first_stage_loader_done,
	output logic                  fpga_cfg_done,
	output logic                  wait_for_interrupt_state,
	output logic [NCORE-1:0]      wdt_stop
);
	int cnt_l;  // Loader copy progress
	int cnt_c;  // Fabric image progress
	int rel;    // Cycles since subsystem left reset
	// Answers come after a bench-chosen delay, so slow loads are seen too
	always @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			first_stage_loader_done <= 1'b0;
			fpga_cfg_done <= 1'b0;
			wait_for_interrupt_state <= 1'b0;
			wdt_stop <= '0;
			cnt_l <= 0;
			cnt_c <= 0;
			rel <= 0;
		end else begin
			first_stage_loader_done <= 1'b0;
			fpga_cfg_done <= 1'b0;
			wdt_stop <= '0;
			if (first_stage_loader_req_q && !first_stage_loader_done) begin
				cnt_l <= (cnt_l >= dly) ? 0 : cnt_l + 1;
				first_stage_loader_done <= (cnt_l >= dly);
			end else begin
				cnt_l <= 0;
			end
			// Factory image always present, so a load always ends
			if (fpga_cfg_req_q && !fpga_cfg_done) begin
				cnt_c <= (cnt_c >= dly) ? 0 : cnt_c + 1;
				fpga_cfg_done <= (cnt_c >= dly);
			end else begin
				cnt_c <= 0;
			end
			if (hps_main_rst_q) begin
				rel <= 0;
			end else if (rel < 8) begin
				rel <= rel + 1;
			end
			// Other cores park in wait for interrupt shortly after boot
			wait_for_interrupt_state <= (rel >= 4);
			// Second-stage loader takes over the boot watchdog
			if (rel == 3 && !hold_wdt) begin
				wdt_stop <= '1;
			end
		end
	end
endmodule

// ---- srs_sequencer_tb_top.sv ----
`timescale 1ns/1ns
module srs_sequencer_tb_top;
	typedef struct {
		logic [8:0] e;
		logic [8:0] m;
		logic [1:0] img;
		logic [2:0] src;
	} srs_note_type;
	// ------------------------------------------------------------
	// Signals
	// ------------------------------------------------------------
	logic clk_sys = 1'b0, rst = 1'b1, config_restart_n = 1'b1;
	logic pin_drv_n = 1'b1, debug_system_reset_n = 1'b1;
	logic jtag_reset_n = 1'b1, secure_mode = 1'b0, single_flash = 1'b0;
	logic sw_cold_req = 1'b0, warm_reset_request_reg = 1'b0;
	logic next_image_valid = 1'b0, flash_to_hps = 1'b0, hold_wdt = 1'b0;
	logic [2:0] boot_select_pins = 3'h0, src_exp;
	logic [3:0] sw_core_rst = 4'h0, wdt_start = 4'h0, wdt_kick = 4'h0;
	logic [3:0] wdt_stop, core_rst_q, core_v;
	logic [4:0] dly = 5'h0;
	srs_pkg::srs_act_type wdt_action = 2'h0;
	srs_pkg::srs_img_type img_q;
	logic cold_rst_pin_n, cold_rst_pin_out, cold_rst_pin_oe, parked;
	logic first_stage_loader_done, fpga_cfg_done;
	logic hps_main_rst_q, hps_debug_rst_q;
	logic hps_keep_rst_q, fpga_rst_q, fpga_erase_q, fpga_cfg_req_q;
	logic first_stage_loader_req_q, init_start_q;
	logic tamper_clear_q, flash_hps_q;
	logic [2:0] cfg_src_q;
	logic [8:0] acc = 9'h0;
	logic [1:0] img_seen = 2'h0;
	logic prev_main, pend = 1'b0;
	srs_note_type notes[$];
	// Cold, pin, debug, restart and the three watchdog actions
	int rnd_list[7] = '{0, 2, 3, 4, 6, 7, 8};
	int n_fail = 0, check_count = 0, rnd;
	// Pulled-up pin: the device wins while it drives low
	assign cold_rst_pin_n = cold_rst_pin_oe ? cold_rst_pin_out : pin_drv_n;
	always #50 clk_sys = ~clk_sys;
	srs_sequencer #(.NCORE(4), .WDT_CYC(50)) u_srs_sequencer (.*,
		.wait_for_interrupt_state(parked));
	srs_partner #(.NCORE(4)) u_srs_partner (.*,
		.wait_for_interrupt_state(parked));
	// ------------------------------------------------------------
	// Checking
	// ------------------------------------------------------------
	task automatic check(input string what, input logic [31:0] seen,
		input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			n_fail++;
			$display("unexpected %s: expected %h, seen %h", what, exp, seen);
		end
	endtask
	// Gather effects while held; judge one cycle after release
	always @(negedge clk_sys) begin
		srs_note_type nt;
		acc = acc | {cold_rst_pin_oe & (cold_rst_pin_out === 1'b0),
			fpga_rst_q, fpga_erase_q, fpga_cfg_req_q,
			first_stage_loader_req_q,
			hps_keep_rst_q, hps_debug_rst_q, init_start_q, tamper_clear_q};
		if (fpga_cfg_req_q) begin
			img_seen = img_q;
		end
		if (pend) begin
			if (notes.size() == 0) begin
				check("spurious reset", 1, 0);
			end else begin
				nt = notes.pop_front();
				check("effects", acc & nt.m, nt.e & nt.m);
				if (nt.e[5]) check("image", img_seen, nt.img);
				check("boot source", cfg_src_q, nt.src);
			end
			acc = '0;
			pend = 1'b0;
		end
		pend = (prev_main === 1'b1) && (hps_main_rst_q === 1'b0);
		prev_main = hps_main_rst_q;
	end
	// ------------------------------------------------------------
	// Stimulus
	// ------------------------------------------------------------
	task automatic wait_done();
		int w;
		w = 0;
		while (notes.size() != 0 && w < 600) begin
			@(negedge clk_sys);
			w++;
		end
		if (w >= 600) check("sequence end", 0, 1);
		hold_wdt = 1'b0;
		repeat (8) @(negedge clk_sys);
	endtask
	task automatic run(input int k, input logic [1:0] im);
		srs_note_type nt;
		case (k)
			0: {nt.e, nt.m} = {9'h114, 9'h1ff};
			1, 7: {nt.e, nt.m} = {9'h000, 9'h1ff};
			4: {nt.e, nt.m} = {9'h034, 9'h03f};
			8: {nt.e, nt.m} = {9'h074, 9'h07f};
			5, 9: {nt.e, nt.m} = {9'h08c, 9'h08c};
			default: {nt.e, nt.m} = {9'h014, 9'h0ff};
		endcase
		// Config restart reloads the current image, not next or factory
		nt.img = (k == 4) ? 2'h0 : im;
		nt.src = src_exp;
		notes.push_back(nt);
		case (k)
			0: sw_cold_req = 1'b1;
			1, 9: warm_reset_request_reg = 1'b1;
			2: pin_drv_n = 1'b0;
			3: debug_system_reset_n = 1'b0;
			4: config_restart_n = 1'b0;
			5: jtag_reset_n = 1'b0;
			default: begin
				wdt_action = 2'(k - 6);
				hold_wdt = 1'b1;
				wdt_start[0] = 1'b1;
			end
		endcase
		@(negedge clk_sys);
		{sw_cold_req, warm_reset_request_reg, wdt_start} = '0;
		// Pins pass a synchroniser, so hold them a few cycles
		repeat (3) @(negedge clk_sys);
		{pin_drv_n, debug_system_reset_n, config_restart_n} = 3'h7;
		jtag_reset_n = 1'b1;
		if (k == 6) begin
			repeat (6) begin
				repeat (20) @(negedge clk_sys);
				wdt_kick[0] = 1'b1;
				@(negedge clk_sys);
				wdt_kick[0] = 1'b0;
			end
			check("kicked watchdog", hps_main_rst_q, 0);
		end
		wait_done();
	endtask
	task automatic final_report();
		$display("checks %0d, mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge clk_sys);
		n_fail++;
		final_report();
	end
	initial begin
		srs_note_type por;
		rnd = $urandom(32'he2a7);
		boot_select_pins = 3'($urandom);
		src_exp = boot_select_pins;
		{por.e, por.m, por.img, por.src} = {9'h08f, 9'h08f, 2'h0, src_exp};
		notes.push_back(por);
		repeat (5) @(negedge clk_sys);
		rst = 1'b0;
		wait_done();
		// Flash handed to the subsystem, then back on warm reset
		flash_to_hps = 1'b1;
		@(negedge clk_sys);
		flash_to_hps = 1'b0;
		repeat (2) @(negedge clk_sys);
		check("flash owner", flash_hps_q, 1);
		// Per core reset of one or more cores must not start a sequence
		core_v = 4'h1 | 4'($urandom);
		sw_core_rst = core_v;
		repeat (3) @(negedge clk_sys);
		check("core reset", core_rst_q, core_v);
		check("main reset", hps_main_rst_q, 0);
		sw_core_rst = 4'h0;
		single_flash = 1'b1;
		run(1, 2'h0);
		check("flash owner", flash_hps_q, 0);
		foreach (rnd_list[i]) begin
			dly = 5'($urandom % 20);
			next_image_valid = 1'($urandom);
			run(rnd_list[i], next_image_valid ? 2'h1 : 2'h2);
		end
		secure_mode = 1'b1;
		run(9, 2'h0);
		secure_mode = 1'b0;
		src_exp = 3'h7;
		run(5, 2'h0);
		final_report();
	end
endmodule
